// [ccms_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// host side: strap levels and serial port driver
// ****************************************************************
module ccms_host_model (
    // clock
    input wire logic core_clk,
    // strap and serial pins
    output logic range_pin_hi,
    output logic range_pin_float,
    output logic swing_pin,
    output logic edge_pin_hi,
    output logic edge_pin_float,
    output logic delay_pin_hi,
    output logic delay_pin_float
);
    ccms_pkg::ccms_level_e rng_q = ccms_pkg::CCMS_LVL_HIGH;
    ccms_pkg::ccms_level_e sw_q = ccms_pkg::CCMS_LVL_LOW;
    ccms_pkg::ccms_level_e edg_q = ccms_pkg::CCMS_LVL_LOW;
    ccms_pkg::ccms_level_e dly_q = ccms_pkg::CCMS_LVL_LOW;
    logic clk_q = 1'b0;
    logic dat_q = 1'b0;
    logic csn_q = 1'b1;
    logic ph_q = 1'b0;
    logic ext;

    // an undriven pin wanders, so its level input toggles every cycle
    always_ff @(posedge core_clk) begin
        ph_q <= ~ph_q;
    end

    assign ext = (rng_q == ccms_pkg::CCMS_LVL_FLOAT);
    always_comb begin
        range_pin_float = ext;
        range_pin_hi = ext ? ph_q : (rng_q == ccms_pkg::CCMS_LVL_HIGH);
        swing_pin = ext ? clk_q : (sw_q == ccms_pkg::CCMS_LVL_HIGH);
        edge_pin_float = !ext && (edg_q == ccms_pkg::CCMS_LVL_FLOAT);
        // host parks the data line low outside a frame so it never wanders
        edge_pin_hi = ext ? (csn_q ? 1'b0 : dat_q) :
            (edge_pin_float ? ph_q : (edg_q == ccms_pkg::CCMS_LVL_HIGH));
        delay_pin_float = !ext && (dly_q == ccms_pkg::CCMS_LVL_FLOAT);
        delay_pin_hi = ext ? csn_q : (delay_pin_float ? ph_q : (dly_q == ccms_pkg::CCMS_LVL_HIGH));
    end

    // floating the delay pin is done only when a scenario asks for it
    task automatic set_straps(input ccms_pkg::ccms_level_e r, s, e, d);
        rng_q <= r;
        sw_q <= s;
        edg_q <= e;
        dly_q <= d;
    endtask

    task automatic set_serial(input logic c, input logic d, input logic n);
        clk_q <= c;
        dat_q <= d;
        csn_q <= n;
    endtask

    // serial clock stands still low outside frames
    task automatic send_word(input logic [15:0] w);
        csn_q <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            dat_q <= w[i];
            repeat (4) @(posedge core_clk);
            clk_q <= 1'b1;
            repeat (4) @(posedge core_clk);
            clk_q <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        csn_q <= 1'b1;
        // deselect must outlast the pin filter or frames merge
        repeat (4) @(posedge core_clk);
    endtask

    // all three user registers first, then a further setting
    task automatic write_user_regs();
        for (int r = 0; r < 3; r++) begin
            send_word({4'(r), 12'h0A5});
        end
        send_word(16'h1F0F);
    endtask
endmodule

`default_nettype wire

// [ccms_pin_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module ccms_pin_sync #(
    parameter int unsigned WIDTH = ccms_pkg::PIN_W,
    parameter logic [WIDTH-1:0] RST_VAL = ccms_pkg::STRAP_RST
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // pins in
    input wire logic [WIDTH-1:0] pin_in,
    // filtered levels out
    output logic [WIDTH-1:0] level_q
);

    // ****************************************************************
    // three stages; a level is taken only when stages two and three agree
    // ****************************************************************
    wire logic [WIDTH-1:0] lvl_w;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_q, s2_q, s3_q, lvl_q;
            logic s1_d, s2_d, s3_d, lvl_d;
            always_comb begin
                s1_d = pin_in[i];
                s2_d = s1_q;
                s3_d = s2_q;
                lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
            end
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    s1_q <= RST_VAL[i];
                    s2_q <= RST_VAL[i];
                    s3_q <= RST_VAL[i];
                    lvl_q <= RST_VAL[i];
                end else if (clk_en) begin
                    s1_q <= s1_d;
                    s2_q <= s2_d;
                    s3_q <= s3_d;
                    lvl_q <= lvl_d;
                end
            end
            assign lvl_w[i] = lvl_q;
        end
    endgenerate

    assign level_q = lvl_w;

endmodule

`default_nettype wire

// [ccms_pkg.sv]
package ccms_pkg;

    // ****************************************************************
    // strap pin vector layout
    // ****************************************************************
    localparam int unsigned PIN_W = 7;
    localparam int unsigned PIN_RANGE_HI = 0;
    localparam int unsigned PIN_RANGE_FLT = 1;
    localparam int unsigned PIN_SWING_HI = 2;
    localparam int unsigned PIN_EDGE_HI = 3;
    localparam int unsigned PIN_EDGE_FLT = 4;
    localparam int unsigned PIN_DELAY_HI = 5;
    localparam int unsigned PIN_DELAY_FLT = 6;
    // range pin driven high, others low: normal range, pin-strapped
    localparam logic [PIN_W-1:0] STRAP_RST = 7'h01;

    // ****************************************************************
    // settle time before the straps are captured
    // ****************************************************************
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned STRAP_SETTLE_NS = 1000;
    localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SETTLE_W = 8;
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(STRAP_SETTLE_CYC - 1);
    localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 8'h00;
    localparam logic [SETTLE_W-1:0] SETTLE_ONE = 8'h01;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h004;
    localparam int unsigned CTRL_RELATCH = 0;
    localparam int unsigned CTRL_SERIAL_HOLD = 1;
    localparam int unsigned ST_EXT_MODE = 0;
    localparam int unsigned ST_RANGE_NORMAL = 1;
    localparam int unsigned ST_SWING_NORMAL = 2;
    localparam int unsigned ST_EDGE_RISING = 3;
    localparam int unsigned ST_DDR = 4;
    localparam int unsigned ST_CAL_LONG = 5;
    localparam int unsigned ST_DELAY_FAULT = 6;
    localparam int unsigned ST_SETTLED = 7;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        CCMS_LVL_LOW,
        CCMS_LVL_HIGH,
        CCMS_LVL_FLOAT
    } ccms_level_e;

    typedef enum logic {
        CCMS_SETTLE,
        CCMS_RUN
    } ccms_state_e;

endpackage

// [ccms_top.sv]
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module ccms_top (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // multi-purpose pins, float detect given per three-level pin
    input wire logic range_pin_hi,
    input wire logic range_pin_float,
    input wire logic swing_pin,
    input wire logic edge_pin_hi,
    input wire logic edge_pin_float,
    input wire logic delay_pin_hi,
    input wire logic delay_pin_float,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ccms_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoded configuration
    output logic ext_mode_q,
    output logic fs_range_normal_q,
    output logic output_swing_level_q,
    output logic output_edge_select_q,
    output logic output_data_clock_ddr_q,
    output logic calibration_delay_select_q,
    output logic delay_pin_fault_q,
    // serial port
    output logic serial_port_en_q,
    output logic serial_bit_clock_q,
    output logic serial_write_line_q,
    output logic serial_chip_select_q
);

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    logic [ccms_pkg::PIN_W-1:0] pin_raw;
    logic [ccms_pkg::PIN_W-1:0] pin_live;

    assign pin_raw = {delay_pin_float, delay_pin_hi, edge_pin_float, edge_pin_hi,
                      swing_pin, range_pin_float, range_pin_hi};

    ccms_pin_sync #(
        .WIDTH(ccms_pkg::PIN_W),
        .RST_VAL(ccms_pkg::STRAP_RST)
    ) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .pin_in(pin_raw),
        .level_q(pin_live)
    );

    // float wins over the level bit, since a floating pin reads undefined
    function automatic ccms_pkg::ccms_level_e lvl3(input logic flt, input logic hi);
        if (flt) begin
            return ccms_pkg::CCMS_LVL_FLOAT;
        end else if (hi) begin
            return ccms_pkg::CCMS_LVL_HIGH;
        end
        return ccms_pkg::CCMS_LVL_LOW;
    endfunction

    // ****************************************************************
    // apb registers
    // ****************************************************************
    logic serial_hold_q, serial_hold_d;
    logic relatch_q, relatch_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic pready_q, pready_d;
    logic [31:0] status_w;
    logic setup_ph;
    ccms_pkg::ccms_state_e state_q, state_d;

    assign setup_ph = psel && !penable;

    always_comb begin
        serial_hold_d = serial_hold_q;
        relatch_d = 1'b0;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        pready_d = 1'b1;
        status_w = ccms_pkg::DATA_ZERO;
        status_w[ccms_pkg::ST_EXT_MODE] = ext_mode_q;
        status_w[ccms_pkg::ST_RANGE_NORMAL] = fs_range_normal_q;
        status_w[ccms_pkg::ST_SWING_NORMAL] = output_swing_level_q;
        status_w[ccms_pkg::ST_EDGE_RISING] = output_edge_select_q;
        status_w[ccms_pkg::ST_DDR] = output_data_clock_ddr_q;
        status_w[ccms_pkg::ST_CAL_LONG] = calibration_delay_select_q;
        status_w[ccms_pkg::ST_DELAY_FAULT] = delay_pin_fault_q;
        status_w[ccms_pkg::ST_SETTLED] = (state_q == ccms_pkg::CCMS_RUN);
        // answer prepared in setup so that pready can stay high: zero wait states
        if (setup_ph) begin
            pslverr_d = 1'b0;
            prdata_d = ccms_pkg::DATA_ZERO;
            if (paddr == ccms_pkg::CTRL_ADDR) begin
                prdata_d[ccms_pkg::CTRL_SERIAL_HOLD] = serial_hold_q;
            end else if (paddr == ccms_pkg::STATUS_ADDR) begin
                prdata_d = status_w;
            end else begin
                pslverr_d = 1'b1;
            end
        end
        if (psel && penable && pwrite && paddr == ccms_pkg::CTRL_ADDR) begin
            serial_hold_d = pwdata[ccms_pkg::CTRL_SERIAL_HOLD];
            relatch_d = pwdata[ccms_pkg::CTRL_RELATCH];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            serial_hold_q <= 1'b0;
            relatch_q <= 1'b0;
            prdata_q <= ccms_pkg::DATA_ZERO;
            pslverr_q <= 1'b0;
            pready_q <= 1'b0;
        end else if (clk_en) begin
            serial_hold_q <= serial_hold_d;
            relatch_q <= relatch_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            pready_q <= pready_d;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pready = pready_q;

    // ****************************************************************
    // strap capture
    // ****************************************************************
    logic [ccms_pkg::SETTLE_W-1:0] settle_q, settle_d;
    logic [ccms_pkg::PIN_W-1:0] strap_q, strap_d;

    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        strap_d = strap_q;
        case (state_q)
            ccms_pkg::CCMS_SETTLE: begin
                if (settle_q == ccms_pkg::SETTLE_LAST) begin
                    strap_d = pin_live;
                    state_d = ccms_pkg::CCMS_RUN;
                    settle_d = ccms_pkg::SETTLE_ZERO;
                end else begin
                    settle_d = settle_q + ccms_pkg::SETTLE_ONE;
                end
            end
            ccms_pkg::CCMS_RUN: begin
                // levels are frozen here; later pin moves only matter as serial lines
                if (relatch_q) begin
                    state_d = ccms_pkg::CCMS_SETTLE;
                end
            end
            default: begin
                state_d = ccms_pkg::CCMS_SETTLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= ccms_pkg::CCMS_SETTLE;
            settle_q <= ccms_pkg::SETTLE_ZERO;
            strap_q <= ccms_pkg::STRAP_RST;
        end else if (clk_en) begin
            state_q <= state_d;
            settle_q <= settle_d;
            strap_q <= strap_d;
        end
    end

    // ****************************************************************
    // mode decode and serial port mux
    // ****************************************************************
    logic ext_d, range_d, swing_d, edge_d, ddr_d, cal_d, fault_d;
    logic sp_en_d, sclk_d, sdat_d, scs_d;
    ccms_pkg::ccms_level_e range_lvl, edge_lvl, delay_lvl;

    always_comb begin
        range_lvl = lvl3(strap_q[ccms_pkg::PIN_RANGE_FLT], strap_q[ccms_pkg::PIN_RANGE_HI]);
        edge_lvl = lvl3(strap_q[ccms_pkg::PIN_EDGE_FLT], strap_q[ccms_pkg::PIN_EDGE_HI]);
        delay_lvl = lvl3(strap_q[ccms_pkg::PIN_DELAY_FLT], strap_q[ccms_pkg::PIN_DELAY_HI]);
        ext_d = (range_lvl == ccms_pkg::CCMS_LVL_FLOAT);
        range_d = (range_lvl == ccms_pkg::CCMS_LVL_HIGH);
        // strapped-only settings keep reset defaults in extended mode
        swing_d = ext_d ? 1'b1 : strap_q[ccms_pkg::PIN_SWING_HI];
        ddr_d = !ext_d && (edge_lvl == ccms_pkg::CCMS_LVL_FLOAT);
        edge_d = !ext_d && (edge_lvl == ccms_pkg::CCMS_LVL_HIGH);
        cal_d = !ext_d && (delay_lvl == ccms_pkg::CCMS_LVL_HIGH);
        fault_d = !ext_d && (delay_lvl == ccms_pkg::CCMS_LVL_FLOAT);
        // serial lines are live pins, never frozen straps; chip select pin is active low
        sp_en_d = ext_d && (state_q == ccms_pkg::CCMS_RUN) && !serial_hold_q;
        sclk_d = sp_en_d && pin_live[ccms_pkg::PIN_SWING_HI];
        sdat_d = sp_en_d && pin_live[ccms_pkg::PIN_EDGE_HI];
        scs_d = sp_en_d && !pin_live[ccms_pkg::PIN_DELAY_HI];
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ext_mode_q <= 1'b0;
            fs_range_normal_q <= 1'b1;
            output_swing_level_q <= 1'b1;
            output_edge_select_q <= 1'b0;
            output_data_clock_ddr_q <= 1'b0;
            calibration_delay_select_q <= 1'b0;
            delay_pin_fault_q <= 1'b0;
            serial_port_en_q <= 1'b0;
            serial_bit_clock_q <= 1'b0;
            serial_write_line_q <= 1'b0;
            serial_chip_select_q <= 1'b0;
        end else if (clk_en) begin
            ext_mode_q <= ext_d;
            fs_range_normal_q <= range_d;
            output_swing_level_q <= swing_d;
            output_edge_select_q <= edge_d;
            output_data_clock_ddr_q <= ddr_d;
            calibration_delay_select_q <= cal_d;
            delay_pin_fault_q <= fault_d;
            serial_port_en_q <= sp_en_d;
            serial_bit_clock_q <= sclk_d;
            serial_write_line_q <= sdat_d;
            serial_chip_select_q <= scs_d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    range_mode_a: assert property (clk_en |=> ext_mode_q == $past(strap_q[ccms_pkg::PIN_RANGE_FLT]))
        else $error("mode does not follow range pin float");
    range_level_a: assert property (clk_en && !strap_q[ccms_pkg::PIN_RANGE_FLT]
        |=> fs_range_normal_q == $past(strap_q[ccms_pkg::PIN_RANGE_HI]))
        else $error("input range does not follow range pin");
    serial_off_a: assert property (!ext_mode_q |-> !serial_port_en_q && !serial_chip_select_q
        && !serial_bit_clock_q && !serial_write_line_q)
        else $error("serial port active in strapped mode");
    swing_sel_a: assert property (clk_en && !strap_q[ccms_pkg::PIN_RANGE_FLT]
        |=> output_swing_level_q == $past(strap_q[ccms_pkg::PIN_SWING_HI]))
        else $error("swing does not follow swing pin");
    edge_sel_a: assert property (clk_en && !strap_q[ccms_pkg::PIN_RANGE_FLT] && !strap_q[ccms_pkg::PIN_EDGE_FLT]
        |=> !output_data_clock_ddr_q && output_edge_select_q == $past(strap_q[ccms_pkg::PIN_EDGE_HI]))
        else $error("edge select wrong");
    ddr_sel_a: assert property (clk_en && !strap_q[ccms_pkg::PIN_RANGE_FLT] && strap_q[ccms_pkg::PIN_EDGE_FLT]
        |=> output_data_clock_ddr_q && !output_edge_select_q)
        else $error("floating edge pin did not give double data rate");
    cal_delay_a: assert property (clk_en && !strap_q[ccms_pkg::PIN_RANGE_FLT] && !strap_q[ccms_pkg::PIN_DELAY_FLT]
        |=> calibration_delay_select_q == $past(strap_q[ccms_pkg::PIN_DELAY_HI]) && !delay_pin_fault_q)
        else $error("calibration delay wrong");
    delay_fault_a: assert property (clk_en && !strap_q[ccms_pkg::PIN_RANGE_FLT] && strap_q[ccms_pkg::PIN_DELAY_FLT]
        |=> delay_pin_fault_q)
        else $error("floating delay pin not flagged");
    serial_map_a: assert property (clk_en && sp_en_d |=> serial_port_en_q
        && serial_bit_clock_q == $past(pin_live[ccms_pkg::PIN_SWING_HI])
        && serial_write_line_q == $past(pin_live[ccms_pkg::PIN_EDGE_HI])
        && serial_chip_select_q == !$past(pin_live[ccms_pkg::PIN_DELAY_HI]))
        else $error("serial pin mapping wrong");
    strap_static_a: assert property (state_q == ccms_pkg::CCMS_RUN && !relatch_q |=> $stable(strap_q))
        else $error("straps moved while running");
    capture_time_a: assert property (clk_en && state_q == ccms_pkg::CCMS_SETTLE
        && settle_q == ccms_pkg::SETTLE_LAST
        |=> state_q == ccms_pkg::CCMS_RUN && strap_q == $past(pin_live))
        else $error("straps not captured at end of settle");
    ext_defaults_a: assert property (clk_en && strap_q[ccms_pkg::PIN_RANGE_FLT] |=> output_swing_level_q
        && !output_edge_select_q && !output_data_clock_ddr_q && !calibration_delay_select_q && !delay_pin_fault_q)
        else $error("strapped-only settings not at defaults in extended mode");
    hold_gate_a: assert property (clk_en && serial_hold_q |=> !serial_port_en_q && !serial_chip_select_q)
        else $error("serial port active while held");
    // bus answer: no wait states, unmapped offsets refused
    bad_addr_a: assert property (clk_en && setup_ph && paddr != ccms_pkg::CTRL_ADDR && paddr != ccms_pkg::STATUS_ADDR
        |=> pslverr && prdata == ccms_pkg::DATA_ZERO)
        else $error("bad address not refused");
    good_addr_a: assert property (clk_en && setup_ph && (paddr == ccms_pkg::CTRL_ADDR || paddr == ccms_pkg::STATUS_ADDR)
        |=> !pslverr)
        else $error("valid address flagged as error");
    pready_up_a: assert property (clk_en |=> pready)
        else $error("wait state inserted");

    ext_seen_c: cover property (serial_port_en_q && serial_chip_select_q);
    ddr_seen_c: cover property (output_data_clock_ddr_q);
    relatch_seen_c: cover property (state_q == ccms_pkg::CCMS_RUN && relatch_q ##1 state_q == ccms_pkg::CCMS_SETTLE);
    bad_addr_c: cover property (psel && penable && pslverr);

endmodule

`default_nettype wire

// [converter_control_mode_select_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module converter_control_mode_select_tb_top;
    logic core_clk, resetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
    logic [ccms_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, s0;
    logic range_pin_hi, range_pin_float, swing_pin, edge_pin_hi, edge_pin_float, delay_pin_hi, delay_pin_float;
    logic ext_mode_q, fs_range_normal_q, output_swing_level_q, output_edge_select_q;
    logic output_data_clock_ddr_q, calibration_delay_select_q, delay_pin_fault_q;
    logic serial_port_en_q, serial_bit_clock_q, serial_write_line_q, serial_chip_select_q;
    logic [10:0] outv, ev, mv;
    logic [7:0] cases [5] = '{8'h40, 8'h15, 8'h58, 8'h0A, 8'h91};
    logic [2:0] pats [5] = '{3'b011, 3'b100, 3'b010, 3'b110, 3'b001};
    int failures = 0;
    int check_count = 0;

    assign outv = {serial_port_en_q, serial_bit_clock_q, serial_write_line_q, serial_chip_select_q,
        delay_pin_fault_q, calibration_delay_select_q, output_data_clock_ddr_q, output_edge_select_q,
        output_swing_level_q, fs_range_normal_q, ext_mode_q};

    ccms_top u_dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .range_pin_hi(range_pin_hi), .range_pin_float(range_pin_float), .swing_pin(swing_pin),
        .edge_pin_hi(edge_pin_hi), .edge_pin_float(edge_pin_float), .delay_pin_hi(delay_pin_hi),
        .delay_pin_float(delay_pin_float), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_mode_q(ext_mode_q), .fs_range_normal_q(fs_range_normal_q),
        .output_swing_level_q(output_swing_level_q), .output_edge_select_q(output_edge_select_q),
        .output_data_clock_ddr_q(output_data_clock_ddr_q),
        .calibration_delay_select_q(calibration_delay_select_q), .delay_pin_fault_q(delay_pin_fault_q),
        .serial_port_en_q(serial_port_en_q), .serial_bit_clock_q(serial_bit_clock_q),
        .serial_write_line_q(serial_write_line_q), .serial_chip_select_q(serial_chip_select_q));

    ccms_host_model u_host (.core_clk(core_clk), .range_pin_hi(range_pin_hi),
        .range_pin_float(range_pin_float), .swing_pin(swing_pin), .edge_pin_hi(edge_pin_hi),
        .edge_pin_float(edge_pin_float), .delay_pin_hi(delay_pin_hi), .delay_pin_float(delay_pin_float));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        check_count++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // poll until the straps have been captured again
    task automatic settle();
        repeat (4) @(posedge core_clk);
        for (int k = 0; k < 300; k++) begin
            apb(1'b0, ccms_pkg::STATUS_ADDR, 32'h0);
            if (rd[ccms_pkg::ST_SETTLED] === 1'b1) break;
        end
        repeat (2) @(posedge core_clk);
    endtask

    // expected outputs from levels: 0 low, 1 high, 2 floating
    task automatic expect_of(input logic [7:0] c);
        logic x;
        x = (c[7:6] == 2'd2);
        ev = {x, 3'b000, !x && c[1:0] == 2'd2, !x && c[1:0] == 2'd1, !x && c[3:2] == 2'd2,
            !x && c[3:2] == 2'd1, x || c[5:4] == 2'd1, c[7:6] == 2'd1, x};
        mv = {1'b1, !x, 3'b111, c[1:0] != 2'd2, 3'b111, !x, 1'b1};
    endtask

    // ****************************************************************
    // clock, watchdog, tests
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        clk_en = 1'b1;
        repeat (2) @(posedge core_clk);
        chk(32'(pready), 32'h0, 32'h1);
        chk(32'(outv), 32'h006, 32'h7FF);
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        settle();
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, er}, 32'h1, 32'hFFFFFFFF);
        chk(rd, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, ccms_pkg::STATUS_ADDR, 32'h0);
        s0 = rd;
        apb(1'b1, ccms_pkg::STATUS_ADDR, 32'hFFFFFFFF);
        apb(1'b0, ccms_pkg::STATUS_ADDR, 32'h0);
        chk(rd, s0, 32'hFFFFFFFF);
        $display("test bus access done");
        // every level of every pin, each case recaptured
        for (int i = 0; i < 5; i++) begin
            u_host.set_straps(ccms_pkg::ccms_level_e'(cases[i][7:6]), ccms_pkg::ccms_level_e'(cases[i][5:4]),
                ccms_pkg::ccms_level_e'(cases[i][3:2]), ccms_pkg::ccms_level_e'(cases[i][1:0]));
            repeat (8) @(posedge core_clk);
            apb(1'b1, ccms_pkg::CTRL_ADDR, 32'h1);
            settle();
            expect_of(cases[i]);
            chk(32'(outv), 32'(ev), 32'(mv));
            apb(1'b0, ccms_pkg::STATUS_ADDR, 32'h0);
            chk(rd, {24'h0, 1'b1, ev[6:0]}, {24'h0, 1'b1, mv[6:0]});
            $display("test strap case %0d done", i);
        end
        // extended mode: pins mapped onto the serial port
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            u_host.set_serial(pats[i][2], pats[i][1], pats[i][0]);
            repeat (8) @(posedge core_clk);
            chk(32'(outv[10:7]), {28'h0, 1'b1, pats[i][2:1], ~pats[i][0]}, {28'h0, 2'b11, ~pats[i][0], 1'b1});
        end
        u_host.set_serial(1'b0, 1'b1, 1'b0);
        apb(1'b1, ccms_pkg::CTRL_ADDR, 32'h2);
        repeat (8) @(posedge core_clk);
        chk(32'(outv[10:7]), 32'h0, 32'hF);
        apb(1'b0, ccms_pkg::CTRL_ADDR, 32'h0);
        chk(rd, 32'h2, 32'h3);
        apb(1'b1, ccms_pkg::CTRL_ADDR, 32'h0);
        repeat (8) @(posedge core_clk);
        chk(32'(outv[10:7]), 32'hB, 32'hF);
        @(posedge core_clk);
        u_host.set_serial(1'b0, 1'b0, 1'b1);
        repeat (4) @(posedge core_clk);
        u_host.write_user_regs();
        repeat (8) @(posedge core_clk);
        chk(32'(outv[10:7]), 32'h8, 32'hD);
        $display("test serial mapping done");
        // straps moved without a recapture leave the mode alone
        u_host.set_straps(ccms_pkg::CCMS_LVL_HIGH, ccms_pkg::CCMS_LVL_LOW, ccms_pkg::CCMS_LVL_LOW,
            ccms_pkg::CCMS_LVL_HIGH);
        repeat (20) @(posedge core_clk);
        chk(32'(outv), 32'(ev), 32'(mv));
        $display("test static straps done");
        summarize();
    end
endmodule

`default_nettype wire
